// ### design/channel_codec_clock_config.sv
// Per-channel codec and receive output clock configuration.
// Assumes cfg_* and data inputs come from logic on sys_clk and
// that pin clocks are well below half the sys_clk rate.
`timescale 1ns/1ns
`include "codec_cfg_params.svh"
module channel_codec_clock_config
  import codec_cfg_pkg::*;
#(
  parameter int NUM_CH = `CHAN_COUNT,
  parameter int CHAR_W = `CHAR_BITS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [NUM_CH-1:0] cfg_load,
  input wire logic cfg_decoder_mode_select,
  input wire logic cfg_decoder_enable,
  input wire logic cfg_rx_output_clock_source,
  input wire logic cfg_rx_clock_rate_select,
  input wire logic [1:0] cfg_primary_detect_threshold,
  input wire logic [1:0] cfg_secondary_detect_threshold,
  input wire logic cfg_encoder_enable,
  output logic [NUM_CH-1:0] decoder_mode_select,
  output logic [NUM_CH-1:0] decoder_enable,
  output logic [NUM_CH-1:0] rx_output_clock_source,
  output logic [NUM_CH-1:0] rx_clock_rate_select,
  output logic [2*NUM_CH-1:0] primary_detect_threshold,
  output logic [2*NUM_CH-1:0] secondary_detect_threshold,
  output logic [NUM_CH-1:0] encoder_enable,
  output logic [NUM_CH-1:0] primary_detect_enable,
  output logic [NUM_CH-1:0] secondary_detect_enable,
  input wire logic [NUM_CH-1:0] channel_reference_clock,
  input wire logic [NUM_CH-1:0] recovered_byte_clock,
  input wire logic [NUM_CH-1:0] ref_half_rate,
  input wire logic [NUM_CH*CHAR_W-1:0] rx_raw_char,
  input wire logic [NUM_CH*CHAR_W-1:0] rx_primary_char,
  input wire logic [NUM_CH*CHAR_W-1:0] rx_alternate_char,
  output logic [NUM_CH*CHAR_W-1:0] rx_char,
  output logic [NUM_CH-1:0] rx_char_tick,
  output logic [NUM_CH-1:0] rx_output_clock_true,
  output logic [NUM_CH-1:0] rx_output_clock_comp,
  input wire logic [NUM_CH-1:0] tx_char_valid,
  input wire logic [NUM_CH*CHAR_W-1:0] tx_raw_char,
  input wire logic [NUM_CH*CHAR_W-1:0] tx_encoded_char,
  output logic [NUM_CH*CHAR_W-1:0] tx_serial_char
);

  // ****************************************
  // Helpers
  // ****************************************

  // Detector runs unless its code is off
  function automatic logic det_on(input logic [1:0] code);
    det_on = (detect_threshold_e'(code) != DET_OFF);
  endfunction : det_on

  // ****************************************
  // Configuration latches
  // ****************************************
  logic [NUM_CH-1:0] next_decoder_mode_select;
  logic [NUM_CH-1:0] next_decoder_enable;
  logic [NUM_CH-1:0] next_rx_output_clock_source;
  logic [NUM_CH-1:0] next_rx_clock_rate_select;
  logic [2*NUM_CH-1:0] next_primary_detect_threshold;
  logic [2*NUM_CH-1:0] next_secondary_detect_threshold;
  logic [NUM_CH-1:0] next_encoder_enable;

  // Per-channel load from the shared setting inputs
  always_comb begin
    next_decoder_mode_select = decoder_mode_select;
    next_decoder_enable = decoder_enable;
    next_rx_output_clock_source = rx_output_clock_source;
    next_rx_clock_rate_select = rx_clock_rate_select;
    next_primary_detect_threshold = primary_detect_threshold;
    next_secondary_detect_threshold = secondary_detect_threshold;
    next_encoder_enable = encoder_enable;
    for (int i = 0; i < NUM_CH; i++) begin
      if (reset) begin
        next_decoder_mode_select[i] = `DEC_MODE_INIT;
        next_decoder_enable[i] = `DEC_ENABLE_INIT;
        next_rx_output_clock_source[i] = `RX_SRC_INIT;
        next_rx_clock_rate_select[i] = `RX_RATE_INIT;
        next_primary_detect_threshold[2*i +: 2] = `DET1_INIT;
        next_secondary_detect_threshold[2*i +: 2] = `DET2_INIT;
        next_encoder_enable[i] = `ENC_ENABLE_INIT;
      end else if (cfg_load[i]) begin
        next_decoder_mode_select[i] = cfg_decoder_mode_select;
        next_decoder_enable[i] = cfg_decoder_enable;
        next_rx_output_clock_source[i] = cfg_rx_output_clock_source;
        next_rx_clock_rate_select[i] = cfg_rx_clock_rate_select;
        next_primary_detect_threshold[2*i +: 2] =
          cfg_primary_detect_threshold;
        next_secondary_detect_threshold[2*i +: 2] =
          cfg_secondary_detect_threshold;
        next_encoder_enable[i] = cfg_encoder_enable;
      end
    end
  end

  // Latch registers
  always_ff @(posedge sys_clk) begin
    decoder_mode_select <= next_decoder_mode_select;
    decoder_enable <= next_decoder_enable;
    rx_output_clock_source <= next_rx_output_clock_source;
    rx_clock_rate_select <= next_rx_clock_rate_select;
    primary_detect_threshold <= next_primary_detect_threshold;
    secondary_detect_threshold <= next_secondary_detect_threshold;
    encoder_enable <= next_encoder_enable;
  end

  // ****************************************
  // Signal detector enables
  // ****************************************
  logic [NUM_CH-1:0] next_primary_detect_enable;
  logic [NUM_CH-1:0] next_secondary_detect_enable;

  // Code 00 switches the analog detector off
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      next_primary_detect_enable[i] = !reset &&
        det_on(primary_detect_threshold[2*i +: 2]);
      next_secondary_detect_enable[i] = !reset &&
        det_on(secondary_detect_threshold[2*i +: 2]);
    end
  end

  // Enable registers
  always_ff @(posedge sys_clk) begin
    primary_detect_enable <= next_primary_detect_enable;
    secondary_detect_enable <= next_secondary_detect_enable;
  end

  // ****************************************
  // Channel datapaths and output clocks
  // ****************************************
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch

    // Output clock pair from the chosen source
    rx_clock_gen u_clock (
      .sys_clk(sys_clk),
      .reset(reset),
      .reference_clock(channel_reference_clock[ch]),
      .recovered_clock(recovered_byte_clock[ch]),
      .source_select(clock_source_e'(rx_output_clock_source[ch])),
      .rate_select(clock_rate_e'(rx_clock_rate_select[ch])),
      .ref_half_rate(ref_half_rate[ch]),
      .char_tick(rx_char_tick[ch]),
      .clock_true(rx_output_clock_true[ch]),
      .clock_comp(rx_output_clock_comp[ch])
    );

    // Decode column, decoder and encoder bypass
    char_path #(
      .CHAR_W(CHAR_W)
    ) u_path (
      .sys_clk(sys_clk),
      .reset(reset),
      .char_tick(rx_char_tick[ch]),
      .decoder_enable(decoder_enable[ch]),
      .decoder_mode_select(decode_mode_e'(decoder_mode_select[ch])),
      .raw_char(rx_raw_char[ch*CHAR_W +: CHAR_W]),
      .primary_char(rx_primary_char[ch*CHAR_W +: CHAR_W]),
      .alternate_char(rx_alternate_char[ch*CHAR_W +: CHAR_W]),
      .rx_char(rx_char[ch*CHAR_W +: CHAR_W]),
      .encoder_enable(encoder_enable[ch]),
      .tx_char_valid(tx_char_valid[ch]),
      .tx_raw_char(tx_raw_char[ch*CHAR_W +: CHAR_W]),
      .tx_encoded_char(tx_encoded_char[ch*CHAR_W +: CHAR_W]),
      .tx_serial_char(tx_serial_char[ch*CHAR_W +: CHAR_W])
    );

    // ****************************************
    // Checks
    // ****************************************
    property p_init_decode;
      @(posedge sys_clk) disable iff (reset)
      $past(reset) |-> decoder_mode_select[ch] == 1'b1
        && decoder_enable[ch] == 1'b1;
    endproperty
    a_init_decode: assert property (p_init_decode)
      else $error("decoder settings wrong after reset");

    property p_init_clock;
      @(posedge sys_clk) disable iff (reset)
      $past(reset) |-> rx_output_clock_source[ch] == 1'b1
        && rx_clock_rate_select[ch] == 1'b1;
    endproperty
    a_init_clock: assert property (p_init_clock)
      else $error("clock settings wrong after reset");

    property p_init_detect;
      @(posedge sys_clk) disable iff (reset)
      $past(reset) |-> primary_detect_threshold[2*ch +: 2] == 2'h2
        && secondary_detect_threshold[2*ch +: 2] == 2'h2
        ##1 primary_detect_enable[ch] && secondary_detect_enable[ch];
    endproperty
    a_init_detect: assert property (p_init_detect)
      else $error("detector settings wrong after reset");

    property p_init_encode;
      @(posedge sys_clk) disable iff (reset)
      $past(reset) |-> encoder_enable[ch] == 1'b1;
    endproperty
    a_init_encode: assert property (p_init_encode)
      else $error("encoder enable wrong after reset");

    property p_hold_unloaded;
      @(posedge sys_clk) disable iff (reset)
      !cfg_load[ch] |=> $stable(decoder_mode_select[ch])
        && $stable(decoder_enable[ch])
        && $stable(rx_output_clock_source[ch])
        && $stable(rx_clock_rate_select[ch])
        && $stable(primary_detect_threshold[2*ch +: 2])
        && $stable(secondary_detect_threshold[2*ch +: 2])
        && $stable(encoder_enable[ch]);
    endproperty
    a_hold_unloaded: assert property (p_hold_unloaded)
      else $error("channel setting moved without its load");

    property p_load_own;
      @(posedge sys_clk) disable iff (reset)
      cfg_load[ch] |=>
        rx_clock_rate_select[ch] == $past(cfg_rx_clock_rate_select)
        && decoder_mode_select[ch] == $past(cfg_decoder_mode_select)
        && encoder_enable[ch] == $past(cfg_encoder_enable);
    endproperty
    a_load_own: assert property (p_load_own)
      else $error("channel load not taken");

    property p_detect_off;
      @(posedge sys_clk) disable iff (reset)
      primary_detect_threshold[2*ch +: 2] == 2'h0
        |=> !primary_detect_enable[ch];
    endproperty
    a_detect_off: assert property (p_detect_off)
      else $error("primary detector on with code 00");

    property p_detect_on;
      @(posedge sys_clk) disable iff (reset)
      secondary_detect_threshold[2*ch +: 2] != 2'h0
        |=> secondary_detect_enable[ch];
    endproperty
    a_detect_on: assert property (p_detect_on)
      else $error("secondary detector off with nonzero code");

    property p_load_rest;
      @(posedge sys_clk) disable iff (reset)
      cfg_load[ch] |=>
        decoder_enable[ch] == $past(cfg_decoder_enable)
        && rx_output_clock_source[ch] == $past(cfg_rx_output_clock_source)
        && primary_detect_threshold[2*ch +: 2]
          == $past(cfg_primary_detect_threshold)
        && secondary_detect_threshold[2*ch +: 2]
          == $past(cfg_secondary_detect_threshold);
    endproperty
    a_load_rest: assert property (p_load_rest)
      else $error("channel load missed a setting");

    property p_detect_on_pri;
      @(posedge sys_clk) disable iff (reset)
      primary_detect_threshold[2*ch +: 2] != 2'h0
        |=> primary_detect_enable[ch];
    endproperty
    a_detect_on_pri: assert property (p_detect_on_pri)
      else $error("primary detector off with nonzero code");

    property p_detect_off_sec;
      @(posedge sys_clk) disable iff (reset)
      secondary_detect_threshold[2*ch +: 2] == 2'h0
        |=> !secondary_detect_enable[ch];
    endproperty
    a_detect_off_sec: assert property (p_detect_off_sec)
      else $error("secondary detector on with code 00");

    property p_detect_reset;
      @(posedge sys_clk)
      reset |=> !primary_detect_enable[ch]
        && !secondary_detect_enable[ch];
    endproperty
    a_detect_reset: assert property (p_detect_reset)
      else $error("detector enabled during reset");

    property p_pair_out;
      @(posedge sys_clk) disable iff (reset)
      rx_output_clock_comp[ch] == !rx_output_clock_true[ch];
    endproperty
    a_pair_out: assert property (p_pair_out)
      else $error("channel output clocks not complementary");

  end : g_ch

endmodule : channel_codec_clock_config

// ### design/codec_cfg_params.svh
// Reset values and sizes of the per-channel codec configuration.
// Included by every design module; the package does not include it.
`ifndef CODEC_CFG_PARAMS_SVH
`define CODEC_CFG_PARAMS_SVH

// Channel count and character width
`define CHAN_COUNT 4
`define CHAR_BITS 10

// Initialization values of the settings
`define DEC_MODE_INIT 1'h1
`define DEC_ENABLE_INIT 1'h1
`define RX_SRC_INIT 1'h1
`define RX_RATE_INIT 1'h1
`define DET1_INIT 2'h2
`define DET2_INIT 2'h2
`define ENC_ENABLE_INIT 1'h1

// Pipeline from synchronised source level to output clock edge, in sys_clk cycles
`define CLK_OUT_LAG 3

`endif

// ### design/codec_cfg_pkg.sv
// Types shared by the codec configuration modules.
// Does not include or use codec_cfg_params.svh.
package codec_cfg_pkg;

  // Receive output clock source
  typedef enum logic {
    SRC_RECOVERED = 1'b0,
    SRC_REFERENCE = 1'b1
  } clock_source_e;

  // Receive output clock rate
  typedef enum logic {
    RATE_FULL = 1'b0,
    RATE_HALF = 1'b1
  } clock_rate_e;

  // Decode table column
  typedef enum logic {
    DEC_ALTERNATE = 1'b0,
    DEC_PRIMARY = 1'b1
  } decode_mode_e;

  // Signal detector trip point
  typedef enum logic [1:0] {
    DET_OFF = 2'b00,
    DET_LOW = 2'b01,
    DET_MID = 2'b10,
    DET_HIGH = 2'b11
  } detect_threshold_e;

endpackage : codec_cfg_pkg

// ### design/rx_clock_gen.sv
// Receive output clock pair and character tick for one channel.
// Assumes pin clocks are much slower than sys_clk.
`timescale 1ns/1ns
`include "codec_cfg_params.svh"
module rx_clock_gen
  import codec_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reference_clock,
  input wire logic recovered_clock,
  input wire clock_source_e source_select,
  input wire clock_rate_e rate_select,
  input wire logic ref_half_rate,
  output logic char_tick,
  output logic clock_true,
  output logic clock_comp
);

  // ****************************************
  // Pin synchronisers and edge pipeline
  // ****************************************
  logic ref_meta, ref_sync, rec_meta, rec_sync;
  logic src_last, level_d, level_dd, tick_d;
  logic src_level, half_ref, follow, tick_now;
  logic next_char_tick, next_true;

  // Source pick and edge detect
  always_comb begin
    src_level = (source_select == SRC_REFERENCE) ? ref_sync : rec_sync;
    half_ref = (source_select == SRC_REFERENCE) && ref_half_rate;
    // Half-rate reference carries a character on both edges
    tick_now = half_ref ? (src_level ^ src_last)
                        : (src_level & ~src_last);
    next_char_tick = reset ? 1'b0 : tick_now;
    follow = half_ref || (rate_select == RATE_FULL);
    // Clock lags the data load by one cycle for setup
    if (reset) begin
      next_true = 1'b0;
    end else if (follow) begin
      next_true = level_dd;
    end else if (tick_d) begin
      next_true = ~clock_true;
    end else begin
      next_true = clock_true;
    end
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    ref_meta <= reference_clock;
    ref_sync <= ref_meta;
    rec_meta <= recovered_clock;
    rec_sync <= rec_meta;
    src_last <= src_level;
    level_d <= src_level;
    level_dd <= level_d;
    char_tick <= next_char_tick;
    tick_d <= char_tick;
    clock_true <= next_true;
    clock_comp <= ~next_true;
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_pair_comp;
    @(posedge sys_clk) disable iff (reset)
    !$past(reset) |-> clock_comp == ~clock_true;
  endproperty
  a_pair_comp: assert property (p_pair_comp)
    else $error("output clock pair not complementary");

  property p_half_rec;
    @(posedge sys_clk) disable iff (reset)
    (source_select == SRC_RECOVERED && rate_select == RATE_HALF
      && tick_d) |=> clock_true != $past(clock_true);
  endproperty
  a_half_rec: assert property (p_half_rec)
    else $error("half-rate recovered clock did not toggle");

  property p_full_rec;
    @(posedge sys_clk) disable iff (reset)
    (source_select == SRC_RECOVERED && rate_select == RATE_FULL)[*4]
      |-> clock_true == $past(rec_sync, `CLK_OUT_LAG);
  endproperty
  a_full_rec: assert property (p_full_rec)
    else $error("full-rate clock does not follow recovered clock");

  property p_half_ref_full;
    @(posedge sys_clk) disable iff (reset)
    (source_select == SRC_REFERENCE && !ref_half_rate
      && rate_select == RATE_HALF && tick_d)
      |=> clock_true != $past(clock_true);
  endproperty
  a_half_ref_full: assert property (p_half_ref_full)
    else $error("half-rate reference clock did not toggle");

  property p_full_ref;
    @(posedge sys_clk) disable iff (reset)
    (source_select == SRC_REFERENCE && !ref_half_rate
      && rate_select == RATE_FULL)[*4]
      |-> clock_true == $past(ref_sync, `CLK_OUT_LAG);
  endproperty
  a_full_ref: assert property (p_full_ref)
    else $error("full-rate clock does not follow reference");

  property p_half_ref;
    @(posedge sys_clk) disable iff (reset)
    (source_select == SRC_REFERENCE && ref_half_rate)[*4]
      |-> clock_true == $past(ref_sync, `CLK_OUT_LAG);
  endproperty
  a_half_ref: assert property (p_half_ref)
    else $error("half-rate reference not followed");

endmodule : rx_clock_gen

// ### design/char_path.sv
// Receive decode selection and transmit encode bypass, one channel.
// Assumes decoded characters arrive from the codec tables.
`timescale 1ns/1ns
`include "codec_cfg_params.svh"
module char_path
  import codec_cfg_pkg::*;
#(
  parameter int CHAR_W = `CHAR_BITS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic char_tick,
  input wire logic decoder_enable,
  input wire decode_mode_e decoder_mode_select,
  input wire logic [CHAR_W-1:0] raw_char,
  input wire logic [CHAR_W-1:0] primary_char,
  input wire logic [CHAR_W-1:0] alternate_char,
  output logic [CHAR_W-1:0] rx_char,
  input wire logic encoder_enable,
  input wire logic tx_char_valid,
  input wire logic [CHAR_W-1:0] tx_raw_char,
  input wire logic [CHAR_W-1:0] tx_encoded_char,
  output logic [CHAR_W-1:0] tx_serial_char
);

  // ****************************************
  // Output registers
  // ****************************************
  logic [CHAR_W-1:0] next_rx_char, next_tx_char;

  // Pick decoded column or raw character
  always_comb begin
    next_rx_char = rx_char;
    next_tx_char = tx_serial_char;
    if (reset) begin
      next_rx_char = '0;
      next_tx_char = '0;
    end else begin
      if (char_tick) begin
        if (!decoder_enable) begin
          next_rx_char = raw_char;
        end else if (decoder_mode_select == DEC_PRIMARY) begin
          next_rx_char = primary_char;
        end else begin
          next_rx_char = alternate_char;
        end
      end
      if (tx_char_valid) begin
        next_tx_char = encoder_enable ? tx_encoded_char
                                      : tx_raw_char;
      end
    end
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    rx_char <= next_rx_char;
    tx_serial_char <= next_tx_char;
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_rx_bypass;
    @(posedge sys_clk) disable iff (reset)
    char_tick && !decoder_enable |=> rx_char == $past(raw_char);
  endproperty
  a_rx_bypass: assert property (p_rx_bypass)
    else $error("bypassed decoder did not pass raw character");

  property p_rx_column;
    @(posedge sys_clk) disable iff (reset)
    char_tick && decoder_enable |=> rx_char ==
      ($past(decoder_mode_select) == DEC_PRIMARY ?
       $past(primary_char) : $past(alternate_char));
  endproperty
  a_rx_column: assert property (p_rx_column)
    else $error("wrong decode column selected");

  property p_rx_hold;
    @(posedge sys_clk) disable iff (reset)
    !char_tick && !$past(reset) |=> $stable(rx_char);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("output register moved without a source tick");

  property p_tx_path;
    @(posedge sys_clk) disable iff (reset)
    tx_char_valid |=> tx_serial_char == ($past(encoder_enable) ?
      $past(tx_encoded_char) : $past(tx_raw_char));
  endproperty
  a_tx_path: assert property (p_tx_path)
    else $error("encoder enable not honoured");

endmodule : char_path

// ### bench/host_capture.sv
// Host model that captures received characters of one channel.
// Assumes the output clock pair is far slower than sys_clk.
`timescale 1ns/1ns
module host_capture (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic half_rate,
  input wire logic clock_true,
  input wire logic clock_comp,
  input wire logic [9:0] data,
  output logic [9:0] captured,
  output logic [7:0] count
);
  // ***************************
  // Capture on output clock edges
  // ***************************
  logic prev_true;
  logic prev_comp;

  // Edge detect and capture
  always_ff @(posedge sys_clk) begin
    prev_true <= clock_true;
    prev_comp <= clock_comp;
    if (reset || clear) begin
      count <= 8'h00;
      captured <= 10'h000;
    end else if ((clock_true && !prev_true) ||
        (half_rate && clock_comp && !prev_comp)) begin
      captured <= data;
      count <= count + 8'h01;
    end
  end
endmodule : host_capture

// ### bench/channel_codec_clock_config_tb_top.sv
// Testbench for the per-channel codec and clock configuration.
// Assumes the design package and header are compiled first.
`timescale 1ns/1ns
module channel_codec_clock_config_tb_top;
  import codec_cfg_pkg::*;
  localparam int CH = 2;
  logic sys_clk, reset, cnt_on, cap_clr, half_mode, prev_t;
  logic [3:0] cfg_load, ref_clk, rec_clk, ref_half, tx_valid;
  logic c_mode, c_dec, c_src, c_rate, c_enc;
  logic [1:0] c_t1, c_t2;
  logic [3:0] mode_q, dec_q, src_q, rate_q, enc_q, pen, sen, tick, ck_t, ck_c;
  logic [7:0] t1_q, t2_q, cap_n;
  logic [39:0] rx_char, tx_out;
  logic [9:0] cap;
  int fails, n_compared, ticks, rises;
  // Scenario table: settings, half-rate reference, char, ticks, rises
  logic [8:0] cw [5] = '{9'h18f, 9'h0a2, 9'h159, 9'h0f4, 9'h1cb};
  logic rh [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [9:0] ex [5] = '{10'h15a, 10'h233, 10'h0a5, 10'h233, 10'h15a};
  int et [5] = '{8, 8, 12, 12, 24};
  int er [5] = '{8, 4, 12, 6, 12};

  channel_codec_clock_config dut_u (.sys_clk(sys_clk), .reset(reset),
    .cfg_load(cfg_load), .cfg_decoder_mode_select(c_mode),
    .cfg_decoder_enable(c_dec), .cfg_rx_output_clock_source(c_src),
    .cfg_rx_clock_rate_select(c_rate), .cfg_primary_detect_threshold(c_t1),
    .cfg_secondary_detect_threshold(c_t2), .cfg_encoder_enable(c_enc),
    .decoder_mode_select(mode_q), .decoder_enable(dec_q),
    .rx_output_clock_source(src_q), .rx_clock_rate_select(rate_q),
    .primary_detect_threshold(t1_q), .secondary_detect_threshold(t2_q),
    .encoder_enable(enc_q), .primary_detect_enable(pen),
    .secondary_detect_enable(sen), .channel_reference_clock(ref_clk),
    .recovered_byte_clock(rec_clk), .ref_half_rate(ref_half),
    .rx_raw_char({10'h0a4, 10'h0a5, 10'h0a6, 10'h0a7}),
    .rx_primary_char({10'h15b, 10'h15a, 10'h15c, 10'h15d}),
    .rx_alternate_char({10'h232, 10'h233, 10'h234, 10'h235}),
    .rx_char(rx_char),
    .rx_char_tick(tick), .rx_output_clock_true(ck_t),
    .rx_output_clock_comp(ck_c), .tx_char_valid(tx_valid),
    .tx_raw_char({10'h3c2, 10'h3c3, 10'h3c4, 10'h3c5}),
    .tx_encoded_char({10'h1e0, 10'h1e1, 10'h1e2, 10'h1e3}),
    .tx_serial_char(tx_out));

  host_capture host_u (.sys_clk(sys_clk), .reset(reset), .clear(cap_clr),
    .half_rate(half_mode), .clock_true(ck_t[CH]), .clock_comp(ck_c[CH]),
    .data(rx_char[CH*10 +: 10]), .captured(cap), .count(cap_n));

  // ***************************
  // Helpers
  // ***************************
  // Settings of one channel as {mode,dec,src,rate,t1,t2,enc}
  function automatic logic [8:0] get(int c);
    return {mode_q[c], dec_q[c], src_q[c], rate_q[c], t1_q[2*c +: 2],
      t2_q[2*c +: 2], enc_q[c]};
  endfunction : get

  task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic load(int c, logic [8:0] w);
    @(posedge sys_clk);
    cfg_load <= 4'h1 << c;
    {c_mode, c_dec, c_src, c_rate, c_t1, c_t2, c_enc} <= w;
    @(posedge sys_clk);
    cfg_load <= 4'h0;
    repeat (2) @(posedge sys_clk);
  endtask : load

  task automatic report_and_stop();
    $display("fails %0d n_compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Edge counters on the observed channel
  always @(negedge sys_clk) begin
    if (cnt_on && tick[CH] === 1'b1) ticks++;
    if (cnt_on && ck_t[CH] === 1'b1 && prev_t === 1'b0) rises++;
    prev_t = ck_t[CH];
  end

  // ***************************
  // Clock, watchdog, main sequence
  // ***************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    #40000;
    fails++;
    report_and_stop();
  end

  initial begin
    reset = 1'b1;
    cnt_on = 1'b0;
    cap_clr = 1'b0;
    half_mode = 1'b0;
    cfg_load = 4'h0;
    ref_clk = 4'h0;
    rec_clk = 4'h0;
    ref_half = 4'h0;
    tx_valid = 4'h0;
    {c_mode, c_dec, c_src, c_rate, c_t1, c_t2, c_enc} = '0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(negedge sys_clk);
    for (int c = 0; c < 4; c++) begin
      chk("init", 10'h1f5, get(c));
      chk("det en", 10'h3, {pen[c], sen[c]});
    end
    for (int k = 0; k < 5; k++) begin
      load(CH, cw[k]);
      chk("settings", cw[k], get(CH));
      chk("det en", {|cw[k][4:3], |cw[k][2:1]}, {pen[CH], sen[CH]});
      @(posedge sys_clk);
      ref_half <= rh[k] << CH;
      half_mode <= rh[k] | cw[k][5];
      cap_clr <= 1'b1;
      @(posedge sys_clk);
      cap_clr <= 1'b0;
      cnt_on <= 1'b1;
      ticks = 0;
      rises = 0;
      for (int i = 0; i < 192; i++) begin
        @(posedge sys_clk);
        ref_clk[CH] <= ((i / 8) % 2) == 1;
        rec_clk[CH] <= ((i / 12) % 2) == 1;
      end
      @(posedge sys_clk);
      ref_clk <= 4'h0;
      rec_clk <= 4'h0;
      repeat (10) @(posedge sys_clk);
      cnt_on <= 1'b0;
      @(negedge sys_clk);
      chk("ticks", 10'(et[k]), 10'(ticks));
      chk("rises", 10'(er[k]), 10'(rises));
      chk("rx char", ex[k], rx_char[CH*10 +: 10]);
      chk("captured", ex[k], cap);
      chk("captures", 10'(et[k]), {2'b00, cap_n});
      @(posedge sys_clk);
      tx_valid <= 4'h1 << CH;
      @(posedge sys_clk);
      tx_valid <= 4'h0;
      @(negedge sys_clk);
      chk("tx", cw[k][0] ? 10'h1e1 : 10'h3c3, tx_out[CH*10 +: 10]);
    end
    for (int c = 0; c < 4; c++) begin
      if (c != CH) chk("other ch", 10'h1f5, get(c));
    end
    report_and_stop();
  end
endmodule : channel_codec_clock_config_tb_top
